// [verilog/status_mon_pkg.sv]
// Constants and types shared by the processor status monitor files
package status_mon_pkg;

  typedef logic [7:0] byte_t;
  typedef logic [15:0] step_len_t;
  typedef logic [1:0] vid_mode_t;

  // Register offsets
  localparam byte_t THROTTLE_CURRENT_SHARE_OFS = 8'h67;
  localparam byte_t THROTTLE_AVERAGE_SHARE_OFS = 8'h68;
  localparam byte_t INPUT_LOW_LEVELS_OFS = 8'h6b;
  localparam byte_t VOLTAGE_IDENT_CAPTURE_OFS = 8'h6c;

  // Reset values and the unmapped read value
  localparam byte_t THROTTLE_CURRENT_SHARE_RST = 8'h00;
  localparam byte_t THROTTLE_AVERAGE_SHARE_RST = 8'h00;
  localparam byte_t VOLTAGE_IDENT_CAPTURE_RST = 8'h00;
  localparam byte_t UNMAPPED_READ_VALUE = 8'h00;

  // Voltage identification layouts
  localparam vid_mode_t VID_MODE_SIX_BIT = 2'h0;
  localparam vid_mode_t VID_MODE_SEVEN_BIT_EXT = 2'h1;
  localparam vid_mode_t VID_MODE_NEW_ONE = 2'h2;
  localparam vid_mode_t VID_MODE_NEW_TWO = 2'h3;

  // Throttle share scale: one interval holds this many steps
  localparam int SHARE_STEPS = 256;
  localparam byte_t LAST_STEP = 8'hff;
  localparam byte_t SHARE_MAX = 8'hff;
  localparam byte_t SHARE_MIN_NONZERO = 8'h01;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int VID_STABLE_NS = 600;
  localparam int VID_STABLE_CYCLES =
    (VID_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [6:0] VID_STABLE_COUNT = 7'(VID_STABLE_CYCLES);

endpackage

// [verilog/vid_filter_if.sv]
// Carrier between the monitor top and its identification pin filter
`timescale 1ns/1ns
interface vid_filter_if;
  import status_mon_pkg::*;
  byte_t pins_synced;
  byte_t stable_code;

  modport filter (
    input pins_synced,
    output stable_code
  );
  modport user (
    output pins_synced,
    input stable_code
  );
endinterface

// [verilog/vid_stable_filter.sv]
// Stability filter that captures identification pins once they settle
`timescale 1ns/1ns
module vid_stable_filter (
  input wire logic sys_clk,
  input wire logic srst,
  vid_filter_if.filter vif
);
  import status_mon_pkg::*;

  byte_t last_ff;
  byte_t nxt_last;
  byte_t code_ff;
  byte_t nxt_code;
  logic [6:0] stable_cnt_ff;
  logic [6:0] nxt_stable_cnt;

  ////////////////////////////////////////////////////////////////////////
  // Any change restarts the count, so a code crossing several bits at
  // different moments is never captured half way
  always_comb begin
    nxt_last = vif.pins_synced;
    nxt_stable_cnt = stable_cnt_ff;
    nxt_code = code_ff;
    if (vif.pins_synced != last_ff) begin
      nxt_stable_cnt = 7'h00;
    end else if (stable_cnt_ff < VID_STABLE_COUNT) begin
      nxt_stable_cnt = stable_cnt_ff + 7'h01;
    end
    if (vif.pins_synced == last_ff && stable_cnt_ff >= VID_STABLE_COUNT) begin
      nxt_code = last_ff;
    end
  end

  // State registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      last_ff <= VOLTAGE_IDENT_CAPTURE_RST;
      code_ff <= VOLTAGE_IDENT_CAPTURE_RST;
      stable_cnt_ff <= 7'h00;
    end else begin
      last_ff <= nxt_last;
      code_ff <= nxt_code;
      stable_cnt_ff <= nxt_stable_cnt;
    end
  end

  assign vif.stable_code = code_ff;

  vid_settle_a: assert property (@(posedge sys_clk)
    disable iff (srst)
    !$stable(code_ff) |-> $past(stable_cnt_ff) >= VID_STABLE_COUNT)
    else $error("identification code changed before pins settled");

endmodule

// [verilog/processor_status_monitor.sv]
// Processor throttle share, input level and identification readout
//
// Summary of operation
// - Each interval end loads current throttle share n, meaning n/256.
// - Writing current share keeps its value but restarts the interval.
// - Nonzero throttle time below one step reads 1; only none reads 0.
// - New average is old average plus new current share, halved.
// - Average updates on the same interval end as current share.
// - Input level bit i reads 1 while input i is low, unlatched.
// - Identification register layout follows one of four mode settings.
// - Six-bit mode: pins 5..0 in bits 5:0, bits 7:6 zero.
// - Seven-bit extended mode: pins 6..0 in bits 6:0, bit 7 zero.
// - First newer mode: pins 6..0 in bits 6:0, bit 7 zero.
// - Second newer mode: pins 7..1 in bits 7:1, bit 0 zero.
// - Identification register updates only after pins stay stable 600 ns.
`timescale 1ns/1ns
module processor_status_monitor (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic processor_throttle_input_n,
  input wire status_mon_pkg::byte_t gp_input_pins,
  input wire status_mon_pkg::byte_t cpu_voltage_ident_pins,
  input wire status_mon_pkg::vid_mode_t voltage_ident_mode,
  input wire status_mon_pkg::step_len_t throttle_step_cycles,
  input wire status_mon_pkg::byte_t reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire status_mon_pkg::byte_t reg_wdata,
  output status_mon_pkg::byte_t reg_rdata,
  output logic reg_rvalid
);
  import status_mon_pkg::*;
  // Checks below are all quiet while reset is held
  default disable iff (srst);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: stage one feeds stage two only
  logic thr_meta_ff;
  logic thr_sync_ff;
  byte_t gpi_meta_ff;
  byte_t gpi_sync_ff;
  byte_t vid_meta_ff;
  byte_t vid_sync_ff;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      thr_meta_ff <= 1'b1;
      thr_sync_ff <= 1'b1;
      gpi_meta_ff <= 8'hff;
      gpi_sync_ff <= 8'hff;
      vid_meta_ff <= 8'h00;
      vid_sync_ff <= 8'h00;
    end else begin
      thr_meta_ff <= processor_throttle_input_n;
      thr_sync_ff <= thr_meta_ff;
      gpi_meta_ff <= gp_input_pins;
      gpi_sync_ff <= gpi_meta_ff;
      vid_meta_ff <= cpu_voltage_ident_pins;
      vid_sync_ff <= vid_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Throttle measurement. An interval is 256 steps of throttle_step_cycles
  // each; active samples are divided by the step length with a running
  // sub-counter, which avoids a hardware divider.
  step_len_t step_len;
  step_len_t cyc_ff;
  step_len_t nxt_cyc;
  byte_t step_idx_ff;
  byte_t nxt_step_idx;
  step_len_t act_sub_ff;
  step_len_t nxt_act_sub;
  logic [8:0] act_share_ff;
  logic [8:0] nxt_act_share;
  logic any_act_ff;
  logic nxt_any_act;
  byte_t cur_ff;
  byte_t nxt_cur;
  byte_t avg_ff;
  byte_t nxt_avg;
  logic [8:0] acc_share;
  logic acc_any;
  logic restart;
  logic interval_end;
  byte_t share_final;

  // Zero step length behaves as one cycle per step
  assign step_len = (throttle_step_cycles == 16'h0000) ? 16'h0001 :
                    throttle_step_cycles;
  assign restart = reg_wr && reg_addr == THROTTLE_CURRENT_SHARE_OFS;
  assign interval_end = step_idx_ff == LAST_STEP &&
                        cyc_ff == step_len - 16'h0001;

  always_comb begin
    acc_share = act_share_ff;
    acc_any = any_act_ff;
    nxt_act_sub = act_sub_ff;
    // Low throttle sample counts as active time
    if (!thr_sync_ff) begin
      acc_any = 1'b1;
      if (act_sub_ff == step_len - 16'h0001) begin
        nxt_act_sub = 16'h0000;
        acc_share = act_share_ff + 9'h001;
      end else begin
        nxt_act_sub = act_sub_ff + 16'h0001;
      end
    end
    // Full interval gives 256; clamp to the register range
    if (acc_share[8]) begin
      share_final = SHARE_MAX;
    end else if (acc_share[7:0] == 8'h00 && acc_any) begin
      share_final = SHARE_MIN_NONZERO;
    end else begin
      share_final = acc_share[7:0];
    end
    nxt_act_share = acc_share;
    nxt_any_act = acc_any;
    nxt_cyc = cyc_ff + 16'h0001;
    nxt_step_idx = step_idx_ff;
    if (cyc_ff == step_len - 16'h0001) begin
      nxt_cyc = 16'h0000;
      nxt_step_idx = step_idx_ff + 8'h01;
    end
    nxt_cur = cur_ff;
    nxt_avg = avg_ff;
    if (restart) begin
      // Register keeps its value; only the capture starts over
      nxt_cyc = 16'h0000;
      nxt_step_idx = 8'h00;
      nxt_act_sub = 16'h0000;
      nxt_act_share = 9'h000;
      nxt_any_act = 1'b0;
    end else if (interval_end) begin
      nxt_cur = share_final;
      nxt_avg = 8'((9'(avg_ff) + 9'(share_final)) >> 1);
      nxt_act_sub = 16'h0000;
      nxt_act_share = 9'h000;
      nxt_any_act = 1'b0;
    end
  end

  // Throttle state registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cyc_ff <= 16'h0000;
      step_idx_ff <= 8'h00;
      act_sub_ff <= 16'h0000;
      act_share_ff <= 9'h000;
      any_act_ff <= 1'b0;
      cur_ff <= THROTTLE_CURRENT_SHARE_RST;
      avg_ff <= THROTTLE_AVERAGE_SHARE_RST;
    end else begin
      cyc_ff <= nxt_cyc;
      step_idx_ff <= nxt_step_idx;
      act_sub_ff <= nxt_act_sub;
      act_share_ff <= nxt_act_share;
      any_act_ff <= nxt_any_act;
      cur_ff <= nxt_cur;
      avg_ff <= nxt_avg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Identification capture through the stability filter
  vid_filter_if vif ();
  assign vif.pins_synced = vid_sync_ff;

  vid_stable_filter u_vid_filter (
    .sys_clk(sys_clk),
    .srst(srst),
    .vif(vif)
  );

  // Layout chosen at read time, so a mode change applies at once
  byte_t vid_layout;
  always_comb begin
    case (voltage_ident_mode)
      VID_MODE_SIX_BIT: begin
        vid_layout = {2'b00, vif.stable_code[5:0]};
      end
      VID_MODE_SEVEN_BIT_EXT: begin
        vid_layout = {1'b0, vif.stable_code[6:0]};
      end
      VID_MODE_NEW_ONE: vid_layout = {1'b0, vif.stable_code[6:0]};
      VID_MODE_NEW_TWO: vid_layout = {vif.stable_code[7:1], 1'b0};
      default: vid_layout = VOLTAGE_IDENT_CAPTURE_RST;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port: data one cycle after the read strobe. Write data is
  // ignored since every register here is read only.
  byte_t nxt_rdata;
  logic nxt_rvalid;
  always_comb begin
    nxt_rvalid = reg_rd;
    nxt_rdata = reg_rdata;
    if (reg_rd) begin
      case (reg_addr)
        THROTTLE_CURRENT_SHARE_OFS: nxt_rdata = cur_ff;
        THROTTLE_AVERAGE_SHARE_OFS: nxt_rdata = avg_ff;
        INPUT_LOW_LEVELS_OFS: nxt_rdata = ~gpi_sync_ff;
        VOLTAGE_IDENT_CAPTURE_OFS: nxt_rdata = vid_layout;
        default: nxt_rdata = UNMAPPED_READ_VALUE;
      endcase
    end
  end

  // Read registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rdata <= nxt_rdata;
      reg_rvalid <= nxt_rvalid;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  cur_hold_a: assert property (@(posedge sys_clk)
    !interval_end |=> $stable(cur_ff))
    else $error("current share changed outside an interval end");

  restart_keep_a: assert property (@(posedge sys_clk)
    restart |=> $stable(cur_ff) && cyc_ff == 16'h0000 && step_idx_ff == 8'h00
      && act_share_ff == 9'h000)
    else $error("write did not restart capture or altered share");

  min_one_a: assert property (@(posedge sys_clk)
    interval_end && !restart && (any_act_ff || !thr_sync_ff)
      |=> cur_ff != 8'h00)
    else $error("active time reported as zero");

  zero_idle_a: assert property (@(posedge sys_clk)
    interval_end && !restart && !any_act_ff && thr_sync_ff |=> cur_ff == 8'h00)
    else $error("idle interval reported nonzero");

  avg_update_a: assert property (@(posedge sys_clk)
    interval_end && !restart |=>
      avg_ff == 8'((9'($past(avg_ff)) + 9'(cur_ff)) >> 1))
    else $error("average share wrong");

  avg_sync_a: assert property (@(posedge sys_clk)
    !$stable(avg_ff) |-> $past(interval_end) && !$past(restart))
    else $error("average moved without current update");

  gpi_level_a: assert property (@(posedge sys_clk)
    reg_rd && reg_addr == INPUT_LOW_LEVELS_OFS |=>
      reg_rvalid && reg_rdata == ~$past(gpi_sync_ff))
    else $error("input level read wrong");

  vid_zero_a: assert property (@(posedge sys_clk)
    reg_rd && reg_addr == VOLTAGE_IDENT_CAPTURE_OFS
      && voltage_ident_mode == VID_MODE_SIX_BIT |=> reg_rdata[7:6] == 2'b00)
    else $error("six-bit layout upper bits not zero");

  vid_top_a: assert property (@(posedge sys_clk)
    reg_rd && reg_addr == VOLTAGE_IDENT_CAPTURE_OFS
      && (voltage_ident_mode == VID_MODE_SEVEN_BIT_EXT
      || voltage_ident_mode == VID_MODE_NEW_ONE) |=>
      reg_rdata == {1'b0, $past(vif.stable_code[6:0])})
    else $error("seven-bit layout wrong");

  vid_shift_a: assert property (@(posedge sys_clk)
    reg_rd && reg_addr == VOLTAGE_IDENT_CAPTURE_OFS
      && voltage_ident_mode == VID_MODE_NEW_TWO |=>
      reg_rdata == {$past(vif.stable_code[7:1]), 1'b0})
    else $error("second newer layout wrong");

endmodule

// [bench/status_pins_model.sv]
// Far-side model of the processor status and identification pins
`timescale 1ns/1ns
module status_pins_model (
  input wire logic sys_clk,
  input wire logic throttle_on,
  input wire status_mon_pkg::byte_t gp_level,
  input wire status_mon_pkg::byte_t vid_level,
  output logic processor_throttle_input_n,
  output status_mon_pkg::byte_t gp_input_pins,
  output status_mon_pkg::byte_t cpu_voltage_ident_pins
);
  import status_mon_pkg::*;
  logic thr_hold;
  byte_t gp_hold;
  byte_t vid_hold;
  // Throttle and input pins idle high, identification pins low, so the monitor starts with nothing active
  initial begin
    thr_hold = 1'b0;
    gp_hold = 8'hff;
    vid_hold = 8'h00;
    processor_throttle_input_n = 1'b1;
    gp_input_pins = 8'hff;
    cpu_voltage_ident_pins = 8'h00;
  end
  // Levels taken on the rising edge, so they never race the bench's
  // own falling-edge writes
  always @(posedge sys_clk) begin
    thr_hold <= throttle_on;
    gp_hold <= gp_level;
    vid_hold <= vid_level;
  end
  // Pins move on the next falling edge, one cycle after the bench
  always @(negedge sys_clk) begin
    processor_throttle_input_n <= ~thr_hold; // Pin is active low
    gp_input_pins <= gp_hold;
    cpu_voltage_ident_pins <= vid_hold;
  end
endmodule

// [bench/processor_status_monitor_tb.sv]
// Self-checking bench for the processor status monitor
`timescale 1ns/1ns
module processor_status_monitor_tb;
  import status_mon_pkg::*;
  logic sys_clk, srst, reg_wr, reg_rd, reg_rvalid, throttle_on;
  logic processor_throttle_input_n;
  byte_t gp_input_pins, cpu_voltage_ident_pins, reg_addr, reg_wdata;
  byte_t reg_rdata, gp_level, vid_level, avg_exp;
  vid_mode_t voltage_ident_mode;
  step_len_t throttle_step_cycles;
  int num_errors, n_tests, cycles;
  ////////////////////////////////////////////////////////////////////////////
  // Design and far-side pins
  processor_status_monitor uut (
    .sys_clk(sys_clk),
    .srst(srst),
    .processor_throttle_input_n(processor_throttle_input_n),
    .gp_input_pins(gp_input_pins),
    .cpu_voltage_ident_pins(cpu_voltage_ident_pins),
    .voltage_ident_mode(voltage_ident_mode),
    .throttle_step_cycles(throttle_step_cycles),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid)
  );
  status_pins_model far_pins (
    .sys_clk(sys_clk),
    .throttle_on(throttle_on),
    .gp_level(gp_level),
    .vid_level(vid_level),
    .processor_throttle_input_n(processor_throttle_input_n),
    .gp_input_pins(gp_input_pins),
    .cpu_voltage_ident_pins(cpu_voltage_ident_pins)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard; the whole run needs about 13000 cycles
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      num_errors = num_errors + 1;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic finish_test();
    if (num_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk_byte(input string name, input byte_t exp,
                          input byte_t got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk_bit(input string name, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Answer stands one cycle, so it is looked at on the next falling edge
  task automatic rd_reg(input byte_t addr, input byte_t exp,
                        input string name);
    @(negedge sys_clk);
    reg_addr = addr;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    chk_bit("read valid", 1'b1, reg_rvalid);
    chk_byte(name, exp, reg_rdata);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic test_reset_values();
    rd_reg(THROTTLE_CURRENT_SHARE_OFS, 8'h00, "current reset");
    rd_reg(THROTTLE_AVERAGE_SHARE_OFS, 8'h00, "average reset");
    rd_reg(INPUT_LOW_LEVELS_OFS, 8'h00, "inputs reset");
    rd_reg(VOLTAGE_IDENT_CAPTURE_OFS, 8'h00, "ident reset");
    rd_reg(8'h69, UNMAPPED_READ_VALUE, "unmapped read");
  endtask
  // Restart with a write, hold throttle for len cycles, check both shares
  task automatic run_interval(input step_len_t step, input logic pre,
                              input int len, input byte_t exp_cur);
    int total;
    total = 256 * int'(step);
    throttle_on = pre;
    wait_cyc(5);
    reg_addr = THROTTLE_CURRENT_SHARE_OFS;
    reg_wdata = 8'ha5;
    reg_wr = 1'b1;
    throttle_step_cycles = step;
    throttle_on = pre | (len > 0);
    @(negedge sys_clk);
    reg_wr = 1'b0;
    if (len > 1) wait_cyc(len - 1);
    throttle_on = 1'b0;
    wait_cyc(total + 8 - len);
    avg_exp = byte_t'((9'(avg_exp) + 9'(exp_cur)) >> 1);
    rd_reg(THROTTLE_CURRENT_SHARE_OFS, exp_cur, "current share");
    rd_reg(THROTTLE_AVERAGE_SHARE_OFS, avg_exp, "average share");
  endtask
  task automatic test_throttle();
    run_interval(16'h0001, 1'b1, 260, 8'hff);
    // Write to the current share offset must leave that share unchanged
    @(negedge sys_clk);
    reg_addr = THROTTLE_CURRENT_SHARE_OFS;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    rd_reg(THROTTLE_CURRENT_SHARE_OFS, 8'hff, "share kept");
    run_interval(16'h0010, 1'b0, 800, 8'h32);
    run_interval(16'h0010, 1'b0, 3, 8'h01);
    run_interval(16'h0010, 1'b0, 0, 8'h00);
  endtask
  task automatic test_inputs();
    gp_level = 8'h5a;
    wait_cyc(5);
    rd_reg(INPUT_LOW_LEVELS_OFS, 8'ha5, "inputs low");
    gp_level = 8'hff;
    wait_cyc(5);
    rd_reg(INPUT_LOW_LEVELS_OFS, 8'h00, "inputs released");
  endtask
  task automatic test_ident();
    byte_t vexp [4];
    vexp = '{8'h17, 8'h57, 8'h57, 8'hd6};
    vid_level = 8'hd7;
    wait_cyc(75);
    for (int m = 0; m < 4; m++) begin
      voltage_ident_mode = vid_mode_t'(m);
      rd_reg(VOLTAGE_IDENT_CAPTURE_OFS, vexp[m], "ident layout");
    end
    // Short glitch must be ignored; a settled change must land late.
    // The read inside the glitch is the one that a bad filter fails.
    vid_level = 8'h2b;
    wait_cyc(30);
    rd_reg(VOLTAGE_IDENT_CAPTURE_OFS, 8'hd6, "ident in glitch");
    vid_level = 8'hd7;
    wait_cyc(75);
    rd_reg(VOLTAGE_IDENT_CAPTURE_OFS, 8'hd6, "ident glitch");
    vid_level = 8'h3c;
    wait_cyc(20);
    rd_reg(VOLTAGE_IDENT_CAPTURE_OFS, 8'hd6, "ident early");
    wait_cyc(60);
    rd_reg(VOLTAGE_IDENT_CAPTURE_OFS, 8'h3c, "ident settled");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    num_errors = 0;
    n_tests = 0;
    cycles = 0;
    avg_exp = 8'h00;
    srst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    throttle_on = 1'b0;
    gp_level = 8'hff;
    vid_level = 8'h00;
    voltage_ident_mode = VID_MODE_SIX_BIT;
    throttle_step_cycles = 16'h0001;
    // Three rising edges under reset, released off the edge
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    srst = 1'b0;
    test_reset_values();
    test_throttle();
    test_inputs();
    test_ident();
    finish_test();
  end
endmodule
